//--- hdl/fssd_pkg.sv
package fssd_pkg;
	// wishbone register byte addresses
	localparam logic [11:0] FSSD_ADR_REC0 = 12'h100;
	localparam logic [11:0] FSSD_ADR_REC1 = 12'h104;
	localparam logic [11:0] FSSD_ADR_REC2 = 12'h108;
	localparam logic [11:0] FSSD_ADR_REC3 = 12'h10c;
	localparam logic [11:0] FSSD_ADR_CTRL = 12'h200;
	localparam logic [11:0] FSSD_ADR_STAT = 12'h204;
	localparam logic [11:0] FSSD_ADR_LOAD = 12'h208;
	// record and control reset values
	localparam logic [31:0] FSSD_REC0_RST = 32'h0000_0000;
	localparam logic [31:0] FSSD_REC1_RST = 32'h00ff_0000;
	localparam logic [31:0] FSSD_REC2_RST = 32'hc800_0000;
	localparam logic [31:0] FSSD_REC3_RST = 32'h0000_0665;
	localparam logic [31:0] FSSD_CTRL_RST = 32'h0000_0000;
	// record 2 field positions
	localparam int FSSD_B_SPF = 14;
	localparam int FSSD_B_HSS = 13;
	localparam int FSSD_B_DPD1 = 12;
	localparam int FSSD_B_DPD0 = 11;
	localparam int FSSD_B_ERDLY = 9;
	localparam int FSSD_B_WRDLY = 8;
	localparam int FSSD_B_BBS = 4;
	localparam int FSSD_B_QIO = 3;
	localparam int FSSD_B_QO = 2;
	localparam int FSSD_B_DIO = 1;
	localparam int FSSD_B_DO = 0;
	// control register bits and boot-block swap limits
	localparam int FSSD_C_SWAP = 0;
	localparam int FSSD_C_PROT = 1;
	localparam int FSSD_C_PFS = 2;
	localparam int FSSD_C_HSS = 3;
	localparam int FSSD_C_WRHS = 8;
	localparam logic [2:0] FSSD_BBS_MAX = 3'h4;
	localparam int FSSD_ADDR_BASE_BIT = 16;
	// timing
	localparam int FSSD_CLK_MHZ = 50;
	localparam int FSSD_US_CYC = FSSD_CLK_MHZ;
	localparam logic [3:0] FSSD_IDLE_N_RST = 4'h5;
	// fetch state
	typedef enum logic [2:0] {
		FSSD_IDLE = 3'b001,
		FSSD_LOAD = 3'b010,
		FSSD_DONE = 3'b100
	} fssd_state_e;
	// decoded behaviour outputs travel together
	typedef struct packed {
		logic stop_prefetch_on_flush;
		logic host_sw_sequencing_enable;
		logic dev1_deep_powerdown_enable;
		logic dev0_deep_powerdown_enable;
		logic erase_poll_delay_enable;
		logic write_poll_delay_enable;
		logic quad_io_read_enable;
		logic quad_output_read_enable;
		logic dual_io_read_enable;
		logic dual_output_read_enable;
	} fssd_cfg_s;
	// discovery results from the flash
	typedef struct packed {
		logic table_found;
		logic dpd1;
		logic dpd0;
		logic qio;
		logic qo;
		logic dio;
		logic dout;
	} fssd_disc_s;
endpackage

//--- hdl/fssd_strap_decode.sv
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module fssd_strap_decode
	import fssd_pkg::*;
#(
	parameter int IDLE_CNT_W = 32
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	// resume-well reset and override strap
	input wire logic resume_well_reset_n,
	input wire logic override_strap,
	// descriptor fetch stream
	input wire logic fetch_valid,
	input wire logic [1:0] fetch_index,
	input wire logic [31:0] fetch_data,
	input wire logic fetch_last,
	input wire fssd_disc_s disc,
	input wire logic comp_dual_out_support,
	input wire logic boot_from_fwh,
	// flash activity
	input wire logic flash_idle,
	input wire logic erase_issued,
	input wire logic write_issued,
	input wire logic [26:0] req_addr,
	input wire logic req_program,
	input wire logic req_in_protected,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// decoded outputs
	output fssd_cfg_s cfg,
	output logic straps_ready,
	output logic fw_engine_disable,
	output logic [26:0] swapped_addr,
	output logic program_refused,
	output logic deep_powerdown_req,
	output logic poll_now
);
	fssd_state_e state, next_state;
	logic [31:0] rec [4];
	logic [31:0] next_rec [4];
	logic [31:0] ctrl, next_ctrl;
	logic rst_q, next_rst_q;
	logic fw_dis, next_fw_dis;
	logic [IDLE_CNT_W-1:0] idle_cnt, next_idle_cnt;
	logic dpd, next_dpd;
	logic ack, next_ack;
	logic [31:0] rdat, next_rdat;
	fssd_cfg_s next_cfg;
	logic [26:0] next_saddr;
	logic refuse, next_refuse;
	logic poll, next_poll;
	logic [3:0] idle_n;
	logic [IDLE_CNT_W-1:0] idle_lim;
	logic [2:0] bbs;
	logic wr_hit;

	// load records and control, latch strap on resume reset rising edge
	always_comb begin
		next_state = state;
		for (int i = 0; i < 4; i++) begin
			next_rec[i] = rec[i];
		end
		next_ctrl = ctrl;
		next_rst_q = resume_well_reset_n;
		next_fw_dis = fw_dis;
		if (resume_well_reset_n && !rst_q) begin
			next_fw_dis = override_strap;
		end
		// a write lands only at the edge where the master sees ack high
		wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && ack;
		case (state)
			FSSD_IDLE: begin
				if (fetch_valid) begin
					next_state = FSSD_LOAD;
				end
			end
			FSSD_LOAD: begin
				if (fetch_last && fetch_valid) begin
					next_state = FSSD_DONE;
				end
			end
			FSSD_DONE: begin
				if (wr_hit && wb_adr_i == FSSD_ADR_LOAD && wb_sel_i[0]
						&& wb_dat_i[0]) begin
					next_state = FSSD_IDLE;
				end
			end
			default: next_state = FSSD_IDLE;
		endcase
		// records only load while fetching, never after
		if (state != FSSD_DONE && fetch_valid) begin
			next_rec[fetch_index] = fetch_data;
			if (fetch_index == 2'd2) begin
				// reset values of the live controls follow the strap
				next_ctrl[FSSD_C_PFS] = fetch_data[FSSD_B_SPF];
				next_ctrl[FSSD_C_HSS] = fetch_data[FSSD_B_HSS];
			end
		end
		if (wr_hit && wb_adr_i == FSSD_ADR_CTRL) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					next_ctrl[b*8 +: 8] = wb_dat_i[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= FSSD_IDLE;
			rec[0] <= FSSD_REC0_RST;
			rec[1] <= FSSD_REC1_RST;
			rec[2] <= FSSD_REC2_RST;
			rec[3] <= FSSD_REC3_RST;
			ctrl <= FSSD_CTRL_RST;
			rst_q <= 1'b1; // pin idles high, so no false edge after reset
			fw_dis <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			rec <= next_rec;
			ctrl <= next_ctrl;
			rst_q <= next_rst_q;
			fw_dis <= next_fw_dis;
		end
	end

	// decode of record 2 against discovery
	always_comb begin
		next_cfg.stop_prefetch_on_flush = ctrl[FSSD_C_PFS];
		next_cfg.host_sw_sequencing_enable = ctrl[FSSD_C_HSS];
		next_cfg.dev1_deep_powerdown_enable =
			rec[2][FSSD_B_DPD1] && disc.dpd1;
		next_cfg.dev0_deep_powerdown_enable =
			rec[2][FSSD_B_DPD0] && disc.dpd0;
		next_cfg.erase_poll_delay_enable = rec[2][FSSD_B_ERDLY];
		next_cfg.write_poll_delay_enable = rec[2][FSSD_B_WRDLY];
		next_cfg.quad_io_read_enable = rec[2][FSSD_B_QIO] && disc.qio;
		next_cfg.quad_output_read_enable = rec[2][FSSD_B_QO] && disc.qo;
		next_cfg.dual_io_read_enable = rec[2][FSSD_B_DIO] && disc.dio;
		// without a parameter table the component bit rules
		next_cfg.dual_output_read_enable = disc.table_found ?
			(rec[2][FSSD_B_DO] && disc.dout) : comp_dual_out_support;
		if (state != FSSD_DONE) begin
			next_cfg = '0; // no cfg bit is set before the fetch ends
		end
		// busy poll starts at once unless the delay strap allows waiting
		next_poll = (erase_issued && !rec[2][FSSD_B_ERDLY])
			|| (write_issued && !rec[2][FSSD_B_WRDLY]);
		bbs = rec[2][FSSD_B_BBS +: 3];
		next_saddr = req_addr;
		if (ctrl[FSSD_C_SWAP]) begin
			if (boot_from_fwh) begin
				next_saddr[FSSD_ADDR_BASE_BIT] = ~req_addr[FSSD_ADDR_BASE_BIT];
			end else if (bbs <= FSSD_BBS_MAX) begin
				next_saddr[FSSD_ADDR_BASE_BIT + 32'(bbs)] =
					~req_addr[FSSD_ADDR_BASE_BIT + 32'(bbs)];
			end // reserved codes leave the address alone
		end
		// protection beats the override strap
		next_refuse = req_program && ctrl[FSSD_C_PROT] && req_in_protected;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfg <= '0;
			poll <= 1'b0;
			swapped_addr <= '0;
			refuse <= 1'b0;
		end else if (clk_en) begin
			cfg <= next_cfg;
			poll <= next_poll;
			swapped_addr <= next_saddr;
			refuse <= next_refuse;
		end
	end

	// idle timer for deep power-down; limit is 2^N microseconds
	always_comb begin
		idle_n = rec[3][3:0];
		idle_lim = IDLE_CNT_W'(FSSD_US_CYC) << idle_n;
		next_idle_cnt = idle_cnt;
		next_dpd = dpd;
		if (!flash_idle || state != FSSD_DONE) begin
			next_idle_cnt = '0;
			next_dpd = 1'b0;
		end else if (idle_cnt >= idle_lim - 1'b1) begin
			next_dpd = cfg.dev0_deep_powerdown_enable
				|| cfg.dev1_deep_powerdown_enable;
		end else begin
			next_idle_cnt = idle_cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			idle_cnt <= '0;
			dpd <= 1'b0;
		end else if (clk_en) begin
			idle_cnt <= next_idle_cnt;
			dpd <= next_dpd;
		end
	end

	// wishbone read mux; ack one cycle after strobe, dropped next cycle
	always_comb begin
		next_ack = wb_cyc_i && wb_stb_i && !ack;
		next_rdat = rdat;
		if (wb_cyc_i && wb_stb_i && !ack && !wb_we_i) begin
			case (wb_adr_i)
				FSSD_ADR_REC0: next_rdat = rec[0];
				FSSD_ADR_REC1: next_rdat = rec[1];
				FSSD_ADR_REC2: next_rdat = rec[2];
				FSSD_ADR_REC3: next_rdat = rec[3];
				FSSD_ADR_CTRL: next_rdat = ctrl;
				FSSD_ADR_STAT: next_rdat = {29'h0, fw_dis, dpd,
					state == FSSD_DONE};
				default: next_rdat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ack <= 1'b0;
			rdat <= '0;
		end else if (clk_en) begin
			ack <= next_ack;
			rdat <= next_rdat;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdat;
	assign straps_ready = state == FSSD_DONE;
	assign fw_engine_disable = fw_dis;
	assign program_refused = refuse;
	assign deep_powerdown_req = dpd;
	assign poll_now = poll;

	// steps of a record 2 word arriving and of a control write answered
	sequence rec2_load_s;
		state != FSSD_DONE && fetch_valid && fetch_index == 2'd2;
	endsequence
	sequence ctrl_write_s;
		wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
			&& wb_adr_i == FSSD_ADR_CTRL;
	endsequence

	// read modes need both the strap bit and discovered support; dual output without a table follows the component bit
	quad_io_gate_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en |=> cfg.quad_io_read_enable |-> $past(rec[2][FSSD_B_QIO]))
		else $error("quad io read enabled without strap");
	quad_out_gate_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && !disc.qo |=> !cfg.quad_output_read_enable)
		else $error("quad output enabled without discovery");
	dual_io_gate_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && !rec[2][FSSD_B_DIO] |=> !cfg.dual_io_read_enable)
		else $error("dual io enabled without strap");
	dual_out_comp_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && state == FSSD_DONE && !disc.table_found |=>
		cfg.dual_output_read_enable == $past(comp_dual_out_support))
		else $error("dual output not from component bit");
	dpd_gate_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && !disc.dpd0 |=> !cfg.dev0_deep_powerdown_enable)
		else $error("deep powerdown without capability");

	// busy polling starts at once when the delay strap is clear; protected programs are refused
	erase_poll_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && erase_issued && !rec[2][FSSD_B_ERDLY] |=> poll_now)
		else $error("erase poll not immediate");
	write_poll_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && write_issued && !rec[2][FSSD_B_WRDLY] |=> poll_now)
		else $error("write poll not immediate");
	protect_refuse_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && req_program && req_in_protected && ctrl[FSSD_C_PROT]
		|=> program_refused)
		else $error("protected program not refused");

	// address inversion for the boot-block swap
	fwh_swap_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && ctrl[FSSD_C_SWAP] && boot_from_fwh |=>
		swapped_addr[16] != $past(req_addr[16]))
		else $error("firmware hub swap missed A16");
	spi_swap_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && ctrl[FSSD_C_SWAP] && !boot_from_fwh
		&& rec[2][6:4] <= 3'h4 |=> (swapped_addr ^ $past(req_addr))
		== (27'h001_0000 << $past(rec[2][6:4])))
		else $error("boot block swap inverted wrong bit");
	reserved_bbs_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && !boot_from_fwh && rec[2][6:4] > 3'h4 |=>
		swapped_addr == $past(req_addr))
		else $error("reserved size inverted bits");

	// strap, fetch, control register, bus ack and power-down behaviour
	strap_latch_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && resume_well_reset_n && !rst_q |=>
		fw_engine_disable == $past(override_strap))
		else $error("override strap not latched");
	fetch_lock_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && state == FSSD_DONE && !wr_hit |=> $stable(rec[2]))
		else $error("records changed after fetch");
	cfg_hold_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && !straps_ready |=> cfg == '0)
		else $error("decoded outputs used before fetch end");
	prefetch_reset_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en ##0 rec2_load_s ##0 !wr_hit |=>
		ctrl[FSSD_C_HSS:FSSD_C_PFS]
		== $past({fetch_data[FSSD_B_HSS], fetch_data[FSSD_B_SPF]}))
		else $error("control reset value not from record 2");
	ctrl_write_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en ##0 ctrl_write_s |=> ctrl[1:0] == $past(wb_dat_i[1:0]))
		else $error("control write did not land");
	ack_pulse_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held longer than one cycle");
	dpd_idle_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		clk_en && !flash_idle |=> !deep_powerdown_req)
		else $error("power-down requested while busy");
endmodule // fssd_strap_decode

//--- test/fssd_flash_model.sv
`timescale 1ns/1ps
// flash side of the fetch: streams the record words after a go pulse
module fssd_flash_model
	import fssd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic go,
	input wire logic slow,
	input wire logic [31:0] rec2,
	input wire logic [31:0] rec3,
	output logic fetch_valid,
	output logic [1:0] fetch_index,
	output logic [31:0] fetch_data,
	output logic fetch_last,
	output logic busy
);
	logic [2:0] idx = 3'h4;
	logic gap = 1'b0;
	logic [31:0] word;
	initial begin
		fetch_valid = 1'b0;
		fetch_last = 1'b0;
		fetch_index = 2'h0;
		fetch_data = 32'h0000_0000;
	end
	// consecutive words from the base, reserved fields at defaults
	always_comb begin
		case (idx[1:0])
			2'h0: word = 32'h5a5a_0f0f;
			2'h1: word = FSSD_REC1_RST;
			2'h2: word = rec2;
			default: word = rec3;
		endcase
	end
	assign busy = (idx < 3'h4);
	// slow mode leaves a gap; idle data is inverted so stale words never match
	always @(posedge ref_clk) begin
		fetch_valid <= 1'b0;
		fetch_last <= 1'b0;
		fetch_data <= ~fetch_data;
		gap <= slow & ~gap;
		if (go) begin
			idx <= 3'h0;
			gap <= 1'b0;
		end else if (busy && !gap) begin
			fetch_valid <= 1'b1;
			fetch_index <= idx[1:0];
			fetch_data <= word;
			fetch_last <= (idx == 3'h3);
			idx <= idx + 3'h1;
		end
	end
endmodule // fssd_flash_model

//--- test/flash_soft_strap_decode_tb_top.sv
`timescale 1ns/1ps
module flash_soft_strap_decode_tb_top;
	import fssd_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic rst_n = 1'b0, ovr = 1'b0, go = 1'b0, slow = 1'b0, fwh = 1'b0;
	logic idle = 1'b0, er = 1'b0, wr = 1'b0, prog = 1'b0, inprot = 1'b0;
	logic cyc = 1'b0, we = 1'b0, cdo = 1'b0, fv, fl, ack, rdy, fwd;
	logic refused, dpd, poll, busy;
	logic ce = 1'b1;
	logic [1:0] fi;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h0000_0000, rng = 32'h0000_0015;
	logic [31:0] rec2 = FSSD_REC2_RST, rdat, fd, rd, r;
	logic [26:0] addr = 27'h000_0000, sw;
	fssd_disc_s disc = 7'h00;
	fssd_cfg_s cfg;
	int bad_count = 0;
	int checks_done = 0;
	// 50 MHz
	always #10 ref_clk = ~ref_clk;
	fssd_strap_decode fssd_strap_decode_inst (.ref_clk(ref_clk),
		.srst(srst), .clk_en(ce), .resume_well_reset_n(rst_n),
		.override_strap(ovr), .fetch_valid(fv), .fetch_index(fi),
		.fetch_data(fd), .fetch_last(fl), .disc(disc),
		.comp_dual_out_support(cdo), .boot_from_fwh(fwh),
		.flash_idle(idle), .erase_issued(er), .write_issued(wr),
		.req_addr(addr), .req_program(prog), .req_in_protected(inprot),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cfg(cfg), .straps_ready(rdy), .fw_engine_disable(fwd),
		.swapped_addr(sw), .program_refused(refused),
		.deep_powerdown_req(dpd), .poll_now(poll));
	fssd_flash_model fssd_flash_model_inst (.ref_clk(ref_clk), .go(go),
		.slow(slow), .rec2(rec2), .rec3(32'h0000_0000), .fetch_valid(fv),
		.fetch_index(fi), .fetch_data(fd), .fetch_last(fl), .busy(busy));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic fssd_cfg_s ecfg(input logic [31:0] v,
		input fssd_disc_s d, input logic c);
		fssd_cfg_s e;
		e = {v[14], v[13], v[12] & d.dpd1, v[11] & d.dpd0, v[9], v[8],
			v[3] & d.qio, v[2] & d.qo, v[1] & d.dio, 1'b0};
		e.dual_output_read_enable = d.table_found ? (v[0] & d.dout) : c;
		return e;
	endfunction
	// a reserved size code inverts nothing; hub boot always flips bit 16
	function automatic logic [26:0] esw(input logic [26:0] a,
		input logic [2:0] c, input logic f);
		if (f)
			return a ^ 27'h001_0000;
		if (c > 3'h4)
			return a;
		return a ^ (27'h001_0000 << c);
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic hang(input string nm);
		bad_count++;
		$display("Error %s expected done seen timeout", nm);
		test_done();
	endtask
	// one classic cycle; held until ack is sampled high
	task automatic wb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (ack !== 1'b1)
			hang("ack");
		rd = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic fetch(input logic [31:0] v);
		int k;
		@(posedge ref_clk);
		rec2 <= v;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (!(rdy === 1'b1 && busy === 1'b0) && k < 100);
		if (k >= 100)
			hang("straps_ready");
		repeat (2) @(posedge ref_clk);
	endtask
	// hang guard at 50000 cycles, far above the test's run length
	initial begin
		#1_000_000;
		hang("run");
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		@(posedge ref_clk);
		chk("ready", {31'h0, rdy}, 0);
		chk("cfg", {22'h0, cfg}, 0);
		for (int i = 0; i < 3; i++) begin
			wb(FSSD_ADR_REC0 + 12'(4 * i), 1'b0, 32'h0000_0000);
			chk("record", rd, i == 0 ? FSSD_REC0_RST : i == 1 ?
				FSSD_REC1_RST : FSSD_REC2_RST);
		end
		wb(FSSD_ADR_REC2, 1'b1, 32'hffff_ffff);
		wb(FSSD_ADR_REC2, 1'b0, 32'h0000_0000);
		chk("record2 ro", rd, FSSD_REC2_RST);
		wb(12'h300, 1'b0, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		$display("register test done");
		// strap sampled only at the rising edge of the resume reset
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			rst_n <= 1'b0;
			ovr <= ~i[0];
			repeat (2) @(posedge ref_clk);
			rst_n <= 1'b1;
			repeat (2) @(posedge ref_clk);
			ovr <= i[0];
			repeat (2) @(posedge ref_clk);
			chk("fw disable", {31'h0, fwd}, {31'h0, ~i[0]});
		end
		$display("strap test done");
		wb(FSSD_ADR_CTRL, 1'b1, 32'h0000_0003);
		wb(FSSD_ADR_CTRL, 1'b0, 32'h0000_0000);
		chk("ctrl", rd, 32'h0000_0003);
		for (int i = 0; i < 11; i++) begin
			rng = xs(rng);
			r = FSSD_REC2_RST | (rng & 32'h0000_7b0f) | {25'h0, i[2:0], 4'h0};
			if (i == 10)
				r = FSSD_REC2_RST | 32'h0000_1800;
			@(posedge ref_clk);
			disc <= (i == 10) ? 7'h7f : rng[22:16];
			cdo <= rng[23];
			// hub boot forced once; reserved size codes always see spi boot
			fwh <= (i == 4) | (rng[24] & rng[28] & ~i[2]);
			slow <= rng[25];
			addr <= rng[26:0];
			if (i > 0)
				wb(FSSD_ADR_LOAD, 1'b1, 32'h0000_0001);
			fetch(r);
			chk("cfg", {22'h0, cfg}, {22'h0, ecfg(r, disc, cdo)});
			chk("swap", {5'h0, sw}, {5'h0, esw(addr, r[6:4], fwh)});
			@(posedge ref_clk);
			er <= i[0];
			wr <= ~i[0];
			prog <= 1'b1;
			inprot <= rng[27];
			@(posedge ref_clk);
			er <= 1'b0;
			wr <= 1'b0;
			prog <= 1'b0;
			@(posedge ref_clk);
			chk("poll", {31'h0, poll}, {31'h0, ~r[8 + i[0]]});
			chk("refused", {31'h0, refused}, {31'h0, rng[27]});
		end
		wb(FSSD_ADR_STAT, 1'b0, 32'h0000_0000);
		chk("status", rd, 32'h0000_0001);
		$display("decode test done");
		// one microsecond limit with a timeout code of zero; a frozen
		// clock enable holds the count, so the request comes late
		@(posedge ref_clk);
		idle <= 1'b1;
		ce <= 1'b0;
		repeat (10) @(posedge ref_clk);
		ce <= 1'b1;
		repeat (FSSD_US_CYC) @(posedge ref_clk);
		chk("dpd early", {31'h0, dpd}, 0);
		@(posedge ref_clk);
		chk("dpd", {31'h0, dpd}, 1);
		wb(FSSD_ADR_STAT, 1'b0, 32'h0000_0000);
		chk("status dpd", rd, 32'h0000_0003);
		$display("power-down test done");
		test_done();
	end
endmodule // flash_soft_strap_decode_tb_top
